//--- clk_consumer_model.sv
// Oscillators and clock consumers that sit around the clock control block.
`timescale 1ns/10ps
`default_nettype none
module clk_consumer_model #(
	parameter int MAIN_HALF = 5,
	parameter int SUB_HALF  = 7
) (
	// Clock.
	input wire logic    i_clk,
	// Enables and clock output from the block.
	input wire logic    i_cpu_clk_en,
	input wire logic    i_periph_clk_en,
	input wire logic    i_clk_out,
	input wire logic    i_main_osc_en,
	input wire logic    i_sub_osc_en,
	// Oscillator waveforms and measurements.
	output logic        o_main_osc = 1'b0,
	output logic        o_sub_osc = 1'b0,
	output logic [7:0]  o_ticks_per_cpu = 8'h00,
	output logic [7:0]  o_cout_half = 8'h00,
	output logic [7:0]  o_tick_gap = 8'h00,
	output logic [15:0] o_cpu_pulses = 16'h0000
);
	int   mc = 0;            // Main half-period counter.
	int   sc = 0;            // Sub half-period counter.
	int   tk = 0;            // Ticks since last CPU pulse.
	int   ck = 0;            // Ticks since last output edge.
	int   gp = 0;            // Cycles since last tick.
	logic cd = 1'b0;         // Output level one cycle ago.
	////////////////////////////////////////
	// A stopped oscillator simply freezes, as a halted crystal would.
	always @(posedge i_clk) begin
		if (i_main_osc_en === 1'b1) begin
			mc = mc + 1;
			if (mc == MAIN_HALF) begin
				mc = 0;
				o_main_osc <= ~o_main_osc;
			end
		end
		if (i_sub_osc_en === 1'b1) begin
			sc = sc + 1;
			if (sc == SUB_HALF) begin
				sc = 0;
				o_sub_osc <= ~o_sub_osc;
			end
		end
		// Measure CPU ratio, output half period and tick spacing.
		if (i_cpu_clk_en === 1'b1) begin
			o_ticks_per_cpu <= 8'(tk);
			o_cpu_pulses <= o_cpu_pulses + 16'h0001;
			tk = 0;
		end
		ck = ck + int'(i_periph_clk_en === 1'b1);
		if (i_clk_out !== cd) begin
			o_cout_half <= 8'(ck);
			ck = 0;
		end
		cd = i_clk_out;
		gp = gp + 1;
		if (i_periph_clk_en === 1'b1) begin
			tk = tk + 1;
			o_tick_gap <= 8'(gp);
			gp = 0;
		end
	end
endmodule
`default_nettype wire

//--- clk_ctl_monitor.sv
// Concurrent checks on the ports of the clock control block.
`timescale 1ns/10ps
`default_nettype none
module clk_ctl_monitor (
	// Clock, reset and enable.
	input wire logic                     i_clk,
	input wire logic                     i_srst,
	input wire logic                     i_ce,
	// Events and observed outputs.
	input wire clk_ctl_pkg::pwr_evt_type i_evt,
	input wire logic                     o_hresp,
	input wire logic                     o_hreadyout,
	input wire logic                     o_cpu_clk_en,
	input wire logic                     o_periph_clk_en,
	input wire logic                     o_main_osc_en,
	input wire logic                     o_idle_mode,
	input wire logic                     o_stop_mode
);
	////////////////////////////////////////
	// All checks share one clock and reset.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// An enabled cycle in Run mode.
	sequence s_run; i_ce && !o_idle_mode && !o_stop_mode; endsequence
	// Idle held long enough for any CPU pulse in flight to drain.
	sequence s_idle_held; o_idle_mode [*3]; endsequence
	property p_hresp_okay; o_hresp == 1'b0; endproperty
	a_hresp_okay: assert property (p_hresp_okay) else $error("bus response not okay");
	property p_reset_out;
		$fell(i_srst) && i_ce |-> (!o_hreadyout && o_main_osc_en && !o_stop_mode
			&& !o_idle_mode) ##1 o_hreadyout;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("bad state after reset");
	property p_stop_in; s_run ##0 i_evt.stop_req |=> o_stop_mode && !o_main_osc_en; endproperty
	a_stop_in: assert property (p_stop_in) else $error("stop not entered");
	property p_idle_in;
		s_run ##0 (i_evt.idle_req && !i_evt.stop_req) |=> o_idle_mode && !o_stop_mode;
	endproperty
	a_idle_in: assert property (p_idle_in) else $error("idle not entered");
	property p_idle_out;
		o_idle_mode && i_ce && (i_evt.ext_irq || i_evt.int_irq) |=> !o_idle_mode;
	endproperty
	a_idle_out: assert property (p_idle_out) else $error("idle not left");
	property p_stop_hold;
		o_stop_mode && !i_evt.ext_irq && !i_evt.int_irq |=> o_stop_mode && !o_main_osc_en;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop left without cause");
	property p_idle_gate; s_idle_held |-> !o_cpu_clk_en; endproperty
	a_idle_gate: assert property (p_idle_gate) else $error("cpu clocked in idle");
	property p_cpu_tick; o_cpu_clk_en |-> $past(o_periph_clk_en); endproperty
	a_cpu_tick: assert property (p_cpu_tick) else $error("cpu pulse without tick");
	property p_cpu_pulse; o_cpu_clk_en |=> !o_cpu_clk_en [*4]; endproperty
	a_cpu_pulse: assert property (p_cpu_pulse) else $error("short cpu period");
endmodule
bind system_clock_control clk_ctl_monitor u_mon (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
	.i_evt(i_evt), .o_hresp(o_hresp), .o_hreadyout(o_hreadyout), .o_cpu_clk_en(o_cpu_clk_en),
	.o_periph_clk_en(o_periph_clk_en), .o_main_osc_en(o_main_osc_en),
	.o_idle_mode(o_idle_mode), .o_stop_mode(o_stop_mode));
`default_nettype wire

//--- clk_ctl_pkg.sv
// Constants, register map and carrier types shared by the clock control block.
package clk_ctl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices, as printed; the byte address is four times the index.
	localparam logic [7:0] IDX_OSC_SEL = 8'hd3;      // Oscillator select control.
	localparam logic [7:0] IDX_SYSCLK  = 8'hd4;      // System clock control.
	localparam logic [7:0] IDX_CLKOUT  = 8'hfe;      // Clock output control.
	localparam int         ADDR_W      = 10;         // Decoded byte address width.
	localparam int         IDX_SHIFT   = 2;          // Index to byte address shift.

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values.
	localparam int         SYS_WAKE_BIT = 7;         // External interrupt wake enable.
	localparam int         SYS_DIV_HI   = 4;         // Divider select, upper bit.
	localparam int         SYS_DIV_LO   = 3;         // Divider select, lower bit.
	localparam logic [7:0] SYS_MASK     = 8'h98;     // Implemented bits of system control.
	localparam logic [7:0] SYS_RST      = 8'h98;     // Wake on, divide by sixteen.
	localparam int         OSC_SUB_BIT  = 0;         // Zero main clock, one sub clock.
	localparam int         OSC_SSTP_BIT = 2;         // Sub oscillator stop.
	localparam int         OSC_MSTP_BIT = 3;         // Main oscillator stop.
	localparam logic [7:0] OSC_MASK     = 8'h0d;     // Implemented bits of oscillator control.
	localparam logic [7:0] OSC_RST      = 8'h00;     // Main clock selected, both running.
	localparam logic [7:0] CLKOUT_MASK  = 8'h03;     // Output frequency field.
	localparam logic [7:0] CLKOUT_RST   = 8'h00;     // System clock divided by sixty-four.

	////////////////////////////////////////////////////////////////////////////////
	// Divider ratios in selected-clock ticks.
	localparam int         DIV_W     = 8;            // Divider counter width.
	localparam logic [7:0] CPU_DIV0  = 8'h01;        // Select code 0: divide by one.
	localparam logic [7:0] CPU_DIV1  = 8'h02;        // Select code 1: divide by two.
	localparam logic [7:0] CPU_DIV2  = 8'h08;        // Select code 2: divide by eight.
	localparam logic [7:0] CPU_DIV3  = 8'h10;        // Select code 3: divide by sixteen.
	localparam logic [7:0] COUT_HALF0 = 8'h20;       // Half period for divide by 64.
	localparam logic [7:0] COUT_HALF1 = 8'h10;       // Half period for divide by 32.
	localparam logic [7:0] COUT_HALF2 = 8'h08;       // Half period for divide by 16.
	localparam logic [7:0] COUT_HALF3 = 8'h04;       // Half period for divide by 8.

	////////////////////////////////////////////////////////////////////////////////
	// Types.
	typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_STOP} pwr_mode_type;

	typedef enum logic [1:0] {REG_NONE, REG_OSC, REG_SYS, REG_COUT} reg_id_type;

	// Address phase of an AHB-Lite transfer.
	typedef struct packed {
		logic              hsel;
		logic [1:0]        htrans;
		logic              hwrite;
		logic [2:0]        hsize;
		logic [ADDR_W-1:0] haddr;
	} ahb_req_type;

	// Wake and sleep events from the CPU core and the interrupt logic.
	typedef struct packed {
		logic idle_req;
		logic stop_req;
		logic ext_irq;
		logic int_irq;
	} pwr_evt_type;

endpackage

//--- clk_sync3.sv
// Three flip-flop synchroniser with agreement filter for one oscillator input.
`timescale 1ns/10ps
`default_nettype none
module clk_sync3 (
	// Clock, reset and enable.
	input  wire logic i_clk,
	input  wire logic i_srst,
	input  wire logic i_ce,
	// Asynchronous input and filtered level.
	input  wire logic i_async,
	output logic      o_level
);

	typedef struct packed {
		logic ff1;       // First stage, read only by the second.
		logic ff2;       // Second stage.
		logic ff3;       // Third stage.
		logic level;     // Filtered level.
	} sync_state_type;

	sync_state_type s_r;     // Registered state.
	sync_state_type s_nxt;   // Next state.

	// The level changes only when the second and third stages agree.
	always_comb begin
		s_nxt     = s_r;
		s_nxt.ff1 = i_async;
		s_nxt.ff2 = s_r.ff1;
		s_nxt.ff3 = s_r.ff2;
		if (s_r.ff2 == s_r.ff3) begin
			s_nxt.level = s_r.ff3;
		end
	end

	// State register with freeze on clock enable.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s_r <= '0;
		end else if (i_ce) begin
			s_r <= s_nxt;
		end
	end

	assign o_level = s_r.level;

endmodule
`default_nettype wire

//--- clk_tick_divider.sv
// Tick divider whose ratio is taken only at a period boundary.
`timescale 1ns/10ps
`default_nettype none
module clk_tick_divider #(
	parameter int CNT_W = 8
) (
	// Clock, reset and enable.
	input  wire logic             i_clk,
	input  wire logic             i_srst,
	input  wire logic             i_ce,
	// Input ticks and ratio; a ratio of zero acts as one.
	input  wire logic             i_tick,
	input  wire logic [CNT_W-1:0] i_ratio,
	output logic                  o_tick
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;     // Ticks seen in this period.
		logic [CNT_W-1:0] ratio;   // Ratio of the running period.
		logic             pulse;   // Registered output tick.
	} div_state_type;

	div_state_type s_r;     // Registered state.
	div_state_type s_nxt;   // Next state.

	// A new ratio is loaded only on wrap, so no period is ever cut short.
	always_comb begin
		s_nxt       = s_r;
		s_nxt.pulse = 1'b0;
		if (i_tick) begin
			if ((s_r.cnt + 1'b1) >= s_r.ratio) begin
				s_nxt.cnt   = '0;
				s_nxt.ratio = i_ratio;
				s_nxt.pulse = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + 1'b1;
			end
		end
	end

	// State register with freeze on clock enable.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s_r <= '0;
		end else if (i_ce) begin
			s_r <= s_nxt;
		end
	end

	assign o_tick = s_r.pulse;

endmodule
`default_nettype wire

//--- system_clock_control.sv
// System clock selection, CPU divider, clock output and power-down control.
//
// Overview of operation
// - Main and sub oscillator feed selected system clock.
// - CPU clock divides system clock by 1/2/8/16.
// - System clock control register read/write at D4H.
// - Bit seven gates external interrupt Stop release.
// - Reset: wake enabled, main running, divide sixteen.
// - Software may speed CPU to 1, 2, 8.
// - Clock output control register read/write at FEH.
// - Output field resets zero, giving divide sixty-four.
// - Stop halts main oscillator; reset, external or (sub clock selected) internal interrupts release.
// - Idle gates only CPU clock; peripherals keep running.
// - Idle ends on reset or any interrupt.
// - Oscillator select bit zero: main zero, sub one.
// - Bit three stops main, bit two stops sub.
// - System control bits four, three pick divider.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module system_clock_control (
	// Clock, reset and enable.
	input  wire logic                     i_clk,
	input  wire logic                     i_srst,
	input  wire logic                     i_ce,
	// AHB-Lite slave.
	input  wire clk_ctl_pkg::ahb_req_type i_ahb,
	input  wire logic                     i_hready,
	input  wire logic [31:0]              i_hwdata,
	output logic [31:0]                   o_hrdata,
	output logic                          o_hreadyout,
	output logic                          o_hresp,
	// Oscillator inputs, from outside the clock domain.
	input  wire logic                     i_main_osc,
	input  wire logic                     i_sub_osc,
	// Power-down requests and wake events, same clock domain.
	input  wire clk_ctl_pkg::pwr_evt_type i_evt,
	// Clock enables and status toward the CPU and peripherals.
	output logic                          o_cpu_clk_en,
	output logic                          o_periph_clk_en,
	output logic                          o_main_osc_en,
	output logic                          o_sub_osc_en,
	output logic                          o_clk_out,
	output logic                          o_idle_mode,
	output logic                          o_stop_mode
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic [7:0]                      sys_ctl;     // System clock control.
		logic [7:0]                      osc_ctl;     // Oscillator select control.
		logic [7:0]                      cout_ctl;    // Clock output control.
		clk_ctl_pkg::pwr_mode_type       mode;        // Power mode.
		logic                            wr_pend;     // Write data phase pending.
		clk_ctl_pkg::reg_id_type         wr_reg;      // Register written in data phase.
		logic [31:0]                     rdata;       // Read data for the data phase.
		logic                            readyout;    // Slave ready.
		logic                            main_d;      // Previous main oscillator level.
		logic                            sub_d;       // Previous sub oscillator level.
		logic                            cpu_en;      // CPU clock enable.
		logic                            periph_en;   // Peripheral clock enable.
		logic                            main_en;     // Main oscillator run.
		logic                            sub_en;      // Sub oscillator run.
		logic                            clk_out;     // Clock output level.
		logic                            idle_f;      // Registered Idle mode flag.
		logic                            stop_f;      // Registered Stop mode flag.
	} ctl_state_type;

	// Reset state; every field is constant.
	localparam ctl_state_type RST_STATE = '{
		sys_ctl:  clk_ctl_pkg::SYS_RST,
		osc_ctl:  clk_ctl_pkg::OSC_RST,
		cout_ctl: clk_ctl_pkg::CLKOUT_RST,
		mode:     clk_ctl_pkg::MODE_RUN,
		wr_reg:   clk_ctl_pkg::REG_NONE,
		main_en:  1'b1,
		sub_en:   1'b1,
		default:  '0
	};

	ctl_state_type s_r;     // Registered state.
	ctl_state_type s_nxt;   // Next state.

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Decodes a byte address to a register; used for reads and writes.
	function automatic clk_ctl_pkg::reg_id_type reg_decode(
		input logic [clk_ctl_pkg::ADDR_W-1:0] addr
	);
		logic [clk_ctl_pkg::ADDR_W-1:0] a_osc;
		logic [clk_ctl_pkg::ADDR_W-1:0] a_sys;
		logic [clk_ctl_pkg::ADDR_W-1:0] a_cout;
		a_osc  = {clk_ctl_pkg::IDX_OSC_SEL, 2'b00};
		a_sys  = {clk_ctl_pkg::IDX_SYSCLK, 2'b00};
		a_cout = {clk_ctl_pkg::IDX_CLKOUT, 2'b00};
		if (addr == a_osc) begin
			reg_decode = clk_ctl_pkg::REG_OSC;
		end else if (addr == a_sys) begin
			reg_decode = clk_ctl_pkg::REG_SYS;
		end else if (addr == a_cout) begin
			reg_decode = clk_ctl_pkg::REG_COUT;
		end else begin
			reg_decode = clk_ctl_pkg::REG_NONE;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator synchronisers and tick sources.

	logic main_lvl;      // Filtered main oscillator level.
	logic sub_lvl;       // Filtered sub oscillator level.
	logic main_tick;     // One rising main edge while it runs.
	logic sub_tick;      // One rising sub edge while it runs.
	logic sel_sub;       // Sub clock selected as system clock.
	logic sys_tick;      // Selected system clock tick.
	logic cpu_tick;      // Divided CPU tick.
	logic cout_tick;     // Clock output half period tick.
	logic [clk_ctl_pkg::DIV_W-1:0] cpu_ratio;    // CPU divider ratio.
	logic [clk_ctl_pkg::DIV_W-1:0] cout_ratio;   // Clock output half period.

	// Main oscillator input.
	clk_sync3 u_sync_main (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_ce    (i_ce),
		.i_async (i_main_osc),
		.o_level (main_lvl)
	);

	// Sub oscillator input.
	clk_sync3 u_sync_sub (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_ce    (i_ce),
		.i_async (i_sub_osc),
		.o_level (sub_lvl)
	);

	// A halted oscillator gives no ticks; selection picks one source.
	always_comb begin
		main_tick = main_lvl & ~s_r.main_d & s_r.main_en;
		sub_tick  = sub_lvl & ~s_r.sub_d & s_r.sub_en;
		sel_sub   = s_r.osc_ctl[clk_ctl_pkg::OSC_SUB_BIT];
		sys_tick  = sel_sub ? sub_tick : main_tick;
	end

	// Divider select decode for the CPU clock.
	always_comb begin
		unique case (s_r.sys_ctl[clk_ctl_pkg::SYS_DIV_HI:clk_ctl_pkg::SYS_DIV_LO])
			2'b00: cpu_ratio = clk_ctl_pkg::CPU_DIV0;
			2'b01: cpu_ratio = clk_ctl_pkg::CPU_DIV1;
			2'b10: cpu_ratio = clk_ctl_pkg::CPU_DIV2;
			2'b11: cpu_ratio = clk_ctl_pkg::CPU_DIV3;
		endcase
	end

	// Frequency select decode for the clock output.
	always_comb begin
		unique case (s_r.cout_ctl[1:0])
			2'b00: cout_ratio = clk_ctl_pkg::COUT_HALF0;
			2'b01: cout_ratio = clk_ctl_pkg::COUT_HALF1;
			2'b10: cout_ratio = clk_ctl_pkg::COUT_HALF2;
			2'b11: cout_ratio = clk_ctl_pkg::COUT_HALF3;
		endcase
	end

	// CPU divider; ratio changes wait for the end of a period.
	clk_tick_divider #(
		.CNT_W (clk_ctl_pkg::DIV_W)
	) u_cpu_div (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_ce    (i_ce),
		.i_tick  (sys_tick),
		.i_ratio (cpu_ratio),
		.o_tick  (cpu_tick)
	);

	// Clock output divider, counting half periods.
	clk_tick_divider #(
		.CNT_W (clk_ctl_pkg::DIV_W)
	) u_cout_div (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_ce    (i_ce),
		.i_tick  (sys_tick),
		.i_ratio (cout_ratio),
		.o_tick  (cout_tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus, registers, power mode and clock enables.

	always_comb begin
		logic                    addr_ok;    // Address phase accepted.
		clk_ctl_pkg::reg_id_type rd_reg;     // Register addressed.
		logic                    wake_ext;   // External interrupt releases Stop.
		logic                    wake_int;   // Internal interrupt releases Stop.
		addr_ok  = 1'b0;
		rd_reg   = clk_ctl_pkg::REG_NONE;
		wake_ext = 1'b0;
		wake_int = 1'b0;
		s_nxt    = s_r;

		// The slave waits only in the first cycle after reset and always answers OKAY.
		s_nxt.readyout = 1'b1;
		s_nxt.main_d   = main_lvl;
		s_nxt.sub_d    = sub_lvl;

		// Data phase of a write updates the latched register.
		if (s_r.wr_pend) begin
			unique case (s_r.wr_reg)
				clk_ctl_pkg::REG_OSC: begin
					s_nxt.osc_ctl = i_hwdata[7:0] & clk_ctl_pkg::OSC_MASK;
				end
				clk_ctl_pkg::REG_SYS: begin
					s_nxt.sys_ctl = i_hwdata[7:0] & clk_ctl_pkg::SYS_MASK;
				end
				clk_ctl_pkg::REG_COUT: begin
					s_nxt.cout_ctl = i_hwdata[7:0] & clk_ctl_pkg::CLKOUT_MASK;
				end
				clk_ctl_pkg::REG_NONE: begin
					// Unmapped writes are dropped.
				end
			endcase
		end

		// Address phase; reads see a write still in its data phase.
		addr_ok       = i_ahb.hsel & i_ahb.htrans[1] & i_hready;
		s_nxt.wr_pend = addr_ok & i_ahb.hwrite;
		s_nxt.wr_reg  = reg_decode(i_ahb.haddr);
		if (addr_ok && !i_ahb.hwrite) begin
			rd_reg = reg_decode(i_ahb.haddr);
			unique case (rd_reg)
				clk_ctl_pkg::REG_OSC:  s_nxt.rdata = {24'h000000, s_nxt.osc_ctl};
				clk_ctl_pkg::REG_SYS:  s_nxt.rdata = {24'h000000, s_nxt.sys_ctl};
				clk_ctl_pkg::REG_COUT: s_nxt.rdata = {24'h000000, s_nxt.cout_ctl};
				clk_ctl_pkg::REG_NONE: s_nxt.rdata = 32'h00000000;
			endcase
		end

		// Wake sources for Stop.
		wake_ext = i_evt.ext_irq & s_r.sys_ctl[clk_ctl_pkg::SYS_WAKE_BIT];
		wake_int = i_evt.int_irq & sel_sub;

		// Power mode sequencing.
		unique case (s_r.mode)
			clk_ctl_pkg::MODE_RUN: begin
				if (i_evt.stop_req) begin
					s_nxt.mode = clk_ctl_pkg::MODE_STOP;
				end else if (i_evt.idle_req) begin
					s_nxt.mode = clk_ctl_pkg::MODE_IDLE;
				end
			end
			clk_ctl_pkg::MODE_IDLE: begin
				if (i_evt.ext_irq || i_evt.int_irq) begin
					s_nxt.mode = clk_ctl_pkg::MODE_RUN;
				end
			end
			clk_ctl_pkg::MODE_STOP: begin
				if (wake_ext || wake_int) begin
					s_nxt.mode = clk_ctl_pkg::MODE_RUN;
				end
			end
			default: begin
				s_nxt.mode = clk_ctl_pkg::MODE_RUN;
			end
		endcase

		// Mode flags are registered so that the mode outputs come straight from flops.
		// They follow the next mode, so they never lag the mode register itself.
		s_nxt.idle_f = (s_nxt.mode == clk_ctl_pkg::MODE_IDLE);
		s_nxt.stop_f = (s_nxt.mode == clk_ctl_pkg::MODE_STOP);

		// Oscillator run controls; Stop halts the main oscillator.
		s_nxt.main_en = ~s_nxt.osc_ctl[clk_ctl_pkg::OSC_MSTP_BIT] &
			(s_nxt.mode != clk_ctl_pkg::MODE_STOP);
		s_nxt.sub_en  = ~s_nxt.osc_ctl[clk_ctl_pkg::OSC_SSTP_BIT];

		// CPU clock is gated in Idle and Stop; peripherals follow the system clock.
		s_nxt.cpu_en    = cpu_tick & (s_r.mode == clk_ctl_pkg::MODE_RUN);
		s_nxt.periph_en = sys_tick;

		// Clock output toggles once per half period.
		if (cout_tick) begin
			s_nxt.clk_out = ~s_r.clk_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	// Reset loads the documented defaults; a low enable freezes everything.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s_r <= RST_STATE;
		end else if (i_ce) begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register except o_hresp, tied to OKAY.

	assign o_hrdata        = s_r.rdata;
	assign o_hreadyout     = s_r.readyout;
	assign o_hresp         = 1'b0;
	assign o_cpu_clk_en    = s_r.cpu_en;
	assign o_periph_clk_en = s_r.periph_en;
	assign o_main_osc_en   = s_r.main_en;
	assign o_sub_osc_en    = s_r.sub_en;
	assign o_clk_out       = s_r.clk_out;
	assign o_idle_mode     = s_r.idle_f;
	assign o_stop_mode     = s_r.stop_f;

endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the system clock control block.
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam logic [7:0] A_OSC = clk_ctl_pkg::IDX_OSC_SEL; // Register indices.
	localparam logic [7:0] A_SYS = clk_ctl_pkg::IDX_SYSCLK;
	localparam logic [7:0] A_OUT = clk_ctl_pkg::IDX_CLKOUT;
	localparam logic [7:0] A_BAD = 8'h80;                    // Unmapped index.
	logic i_clk, i_srst, i_ce, hready, hresp, mosc, sosc;
	logic cpu_en, per_en, mosc_en, sosc_en, cout, idle_m, stop_m;
	logic [31:0] hwdata, hrdata;
	logic [7:0] tpc, half, gap, v;
	logic [15:0] npc;
	clk_ctl_pkg::ahb_req_type ahb;
	clk_ctl_pkg::pwr_evt_type evt;
	logic [31:0] exp_q[$];   // Expected read data, oldest first.
	logic rd_ph = 1'b0;      // A read data phase is under way.
	int fails = 0, samples_checked = 0, cyc = 0, k;
	system_clock_control dut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_ahb(ahb),
		.i_hready(hready), .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(hresp), .i_main_osc(mosc), .i_sub_osc(sosc), .i_evt(evt),
		.o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en), .o_main_osc_en(mosc_en),
		.o_sub_osc_en(sosc_en), .o_clk_out(cout), .o_idle_mode(idle_m), .o_stop_mode(stop_m));
	clk_consumer_model u_far (.i_clk(i_clk), .i_cpu_clk_en(cpu_en), .i_periph_clk_en(per_en),
		.i_clk_out(cout), .i_main_osc_en(mosc_en), .i_sub_osc_en(sosc_en), .o_main_osc(mosc),
		.o_sub_osc(sosc), .o_ticks_per_cpu(tpc), .o_cout_half(half), .o_tick_gap(gap),
		.o_cpu_pulses(npc));
	////////////////////////////////////////
	// Compare and report.
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d, failed %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// One single AHB-Lite transfer, entered just after a rising edge.
	task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] d);
		ahb <= '{1'b1, 2'b10, w, 3'b010, {idx, 2'b00}};
		do @(posedge i_clk); while (hready !== 1'b1);
		ahb <= '0;
		hwdata <= d;
		do @(posedge i_clk); while (hready !== 1'b1);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, {24'h0, d});
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(idx, 1'b0, 32'h0);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// One-cycle power event, then one cycle for the mode to settle.
	task automatic ev(input logic [3:0] e);
		evt <= clk_ctl_pkg::pwr_evt_type'(e);
		@(posedge i_clk);
		evt <= '0;
		wt(1);
	endtask
	////////////////////////////////////////
	// Clock and hang guard.
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			end_of_test();
		end
	end
	// Read data watcher: takes the oldest note when a data phase ends.
	always @(posedge i_clk) begin
		if (rd_ph && hready === 1'b1 && exp_q.size() > 0) cmp(hrdata, exp_q.pop_front());
		if (hready === 1'b1) rd_ph <= ahb.hsel && ahb.htrans[1] && !ahb.hwrite;
	end
	////////////////////////////////////////
	// Main sequence.
	initial begin
		{i_srst, i_ce, ahb, hwdata, evt} = {1'b1, 1'b1, 17'h0, 32'h0, 4'h0};
		void'($urandom(32'ha8b9a362));
		wt(2);
		i_srst <= 1'b0;
		wt(1);
		rd(A_SYS, 8'h98);
		rd(A_OUT, 8'h00);
		rd(A_OSC, 8'h00);
		rd(A_BAD, 8'h00);
		$display("test reset_values done");
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			wr(A_SYS, v);
			rd(A_SYS, v & 8'h98);
			wr(A_OUT, v);
			rd(A_OUT, v & 8'h03);
			wr(A_BAD, v);
			rd(A_BAD, 8'h00);
		end
		$display("test register_access done");
		for (int c = 0; c < 4; c++) begin
			wr(A_SYS, {3'b100, 2'(c), 3'b000});
			k = int'(npc) + 3;
			while (int'(npc) < k) @(posedge i_clk);
			cmp(tpc, (c == 0) ? 1 : (c == 1) ? 2 : (c == 2) ? 8 : 16);
			wr(A_OUT, 8'(c));
			repeat (3) begin
				v[0] = cout;
				while (cout === v[0]) @(posedge i_clk);
			end
			cmp(half, 8'h20 >> c);
		end
		$display("test dividers done");
		wr(A_OSC, 8'h01);
		wt(60);
		cmp(gap, 8'd14);
		wr(A_OSC, 8'h09);
		wt(4);
		cmp(mosc_en, 1'b0);
		ev(4'h4);
		ev(4'h1);
		cmp(stop_m, 1'b0);
		wr(A_OSC, 8'h05);
		wt(4);
		cmp({mosc_en, sosc_en}, 2'b10);
		wr(A_OSC, 8'h00);
		wt(60);
		cmp(gap, 8'd10);
		$display("test oscillators done");
		ev(4'hc);
		cmp({stop_m, idle_m, mosc_en}, 3'b100);
		ev(4'h2);
		cmp({stop_m, mosc_en}, 2'b01);
		wr(A_SYS, 8'h18);
		ev(4'h4);
		ev(4'h2);
		ev(4'h1);
		cmp(stop_m, 1'b1);
		wr(A_SYS, 8'h98);
		ev(4'h2);
		cmp(stop_m, 1'b0);
		for (int i = 0; i < 2; i++) begin
			ev(4'h8);
			wt(3);
			k = int'(npc);
			v = 8'h00;
			repeat (100) begin
				@(posedge i_clk);
				v = v + 8'(per_en === 1'b1);
			end
			cmp({idle_m, 8'(int'(npc) - k), 1'(v >= 8'd8)}, {1'b1, 8'h00, 1'b1});
			ev(i ? 4'h2 : 4'h1);
			cmp(idle_m, 1'b0);
		end
		$display("test power_modes done");
		wr(A_SYS, 8'h08);
		wr(A_OUT, 8'h02);
		i_srst <= 1'b1;
		wt(2);
		i_srst <= 1'b0;
		wt(1);
		rd(A_SYS, 8'h98);
		rd(A_OUT, 8'h00);
		$display("test second_reset done");
		wt(2);
		end_of_test();
	end
endmodule
`default_nettype wire
